/* common/period_timer_regs.vh */
/*
 * Register indices, field positions, reset values and counts of the
 * 8-bit period match timer. Definitions only; included by its bare name.
 */
`ifndef PERIOD_TIMER_REGS_VH
`define PERIOD_TIMER_REGS_VH

// Register indices (byte address is four times the index)
`define IDX_INTERRUPT_CONTROL      10'h00b
`define IDX_PERIPHERAL_IRQ_FLAGS   10'h00c
`define IDX_TIMER_COUNT            10'h011
`define IDX_TIMER_CONTROL          10'h012
`define IDX_PERIPHERAL_IRQ_ENABLES 10'h08c
`define IDX_TIMER_PERIOD           10'h092

// Reset values
`define RST_INTERRUPT_CONTROL      8'h00
`define RST_PERIPHERAL_IRQ_FLAGS   8'h00
`define RST_TIMER_COUNT            8'h00
`define RST_TIMER_CONTROL          7'h00
`define RST_PERIPHERAL_IRQ_ENABLES 8'h00
`define RST_TIMER_PERIOD           8'hff

// Timer control fields
`define CTL_PRESCALE_LO            0
`define CTL_PRESCALE_HI            1
`define CTL_TIMER_ON               2
`define CTL_POSTSCALE_LO           3
`define CTL_POSTSCALE_HI           6

// Flag and enable bit of the timer match
`define BIT_TIMER_MATCH            1

// Prescale selections and their terminal counts
`define PRESCALE_SEL_DIV1          2'h0
`define PRESCALE_SEL_DIV4          2'h1
`define PRESCALE_LIMIT_DIV1        4'h0
`define PRESCALE_LIMIT_DIV4        4'h3
`define PRESCALE_LIMIT_DIV16       4'hf

// Oscillator to instruction clock ratio
`define INSTR_CLOCK_DIV            4

`endif

/* hw/cycle_divider.v */
/*
 * Free-running divider giving a one-cycle enable every RATIO clocks.
 * Assumes one clock; the enable stands for exactly one cycle.
 */
`timescale 1ns/1ps
module cycle_divider #(
    parameter RATIO = 4
) (
    input  wire       clk_i,
    input  wire       nrst_i,
    output reg        tick_o
);
    localparam [7:0] LAST = RATIO - 1;

    reg [7:0] cnt;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt    <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt == LAST);
            if (cnt == LAST) begin
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule // cycle_divider

/* hw/period_match_timer_8bit.v */
/*
 * 8-bit period match timer with prescaler, postscaler, sticky match flag,
 * interrupt mask and an APB register slave.
 * Assumes one 50 MHz clock taken as the oscillator, APB inputs synchronous.
 */
//
// Contract
// - The counter counts up from zero until it equals the period and reloads zero on the next increment.
// - The period register resets to all ones.
// - The counter resets to zero on any reset and software can read and write it.
// - The counter is clocked by oscillator/4 through a prescaler of 1, 4 or 16 chosen by control bits 1:0.
// - Every match passes a 4-bit postscaler giving one output per n+1 matches, n in control bits 6:3.
// - Each postscaler output sets and holds the timer match flag at bit 1 of the flag register.
// - Writing the counter, writing the control register or a reset clears both scaler counters.
// - Writing the control register leaves the counter value unchanged.
// - The timer runs only while control bit 2 is one.
// - The period register is readable and writable at any time.
// - The match pulse before the postscaler is exported to the serial port block.
// - The counter and its period match are offered as the time base for the PWM block.
`timescale 1ns/1ps
`include "period_timer_regs.vh"
module period_match_timer_8bit #(
    parameter ADDR_WIDTH = 12
) (
    input  wire                  clk_i,
    input  wire                  nrst_i,
    input  wire                  psel_i,
    input  wire                  penable_i,
    input  wire                  pwrite_i,
    input  wire [ADDR_WIDTH-1:0] paddr_i,
    input  wire [31:0]           pwdata_i,
    input  wire [3:0]            pstrb_i,
    output reg  [31:0]           prdata_o,
    output reg                   pready_o,
    output reg                   pslverr_o,
    output reg                   irq_o,
    output reg                   ssp_match_o,
    output reg                   pwm_match_o,
    output reg  [7:0]            pwm_count_o,
    output reg  [7:0]            pwm_period_o
);
    // Register state
    reg  [7:0] interrupt_control;
    reg        timer_match_flag;
    reg  [7:0] peripheral_irq_enables;
    reg  [7:0] timer_count;
    reg  [6:0] timer_control;
    reg  [7:0] timer_period;

    // Bus decode
    wire [9:0] word_index;
    wire       setup_phase;
    wire       access_done;
    wire       wr_done;
    wire       rd_done;
    wire       lane0;
    wire       hit_interrupt_control;
    wire       hit_flags;
    wire       hit_count;
    wire       hit_control;
    wire       hit_enables;
    wire       hit_period;
    wire       hit_any;

    assign word_index  = paddr_i[11:2];
    assign setup_phase = psel_i && !penable_i;
    assign access_done = psel_i && penable_i && pready_o;
    assign wr_done     = access_done && pwrite_i;
    assign rd_done     = access_done && !pwrite_i;
    assign lane0       = pstrb_i[0];

    assign hit_interrupt_control  = (word_index == `IDX_INTERRUPT_CONTROL);
    assign hit_flags   = (word_index == `IDX_PERIPHERAL_IRQ_FLAGS);
    assign hit_count   = (word_index == `IDX_TIMER_COUNT);
    assign hit_control = (word_index == `IDX_TIMER_CONTROL);
    assign hit_enables = (word_index == `IDX_PERIPHERAL_IRQ_ENABLES);
    assign hit_period  = (word_index == `IDX_TIMER_PERIOD);
    assign hit_any     = hit_interrupt_control | hit_flags | hit_count
                       | hit_control | hit_enables | hit_period;

    // Software write strobes
    wire count_write;
    wire control_write;
    wire period_write;
    wire enables_write;
    wire interrupt_control_write;

    assign count_write   = wr_done && hit_count && lane0;
    assign control_write = wr_done && hit_control && lane0;
    assign period_write  = wr_done && hit_period && lane0;
    assign enables_write = wr_done && hit_enables && lane0;
    assign interrupt_control_write  = wr_done && hit_interrupt_control && lane0;

    // Control fields
    wire       timer_on;
    wire [1:0] prescale_select;
    wire [3:0] postscale_select;

    assign timer_on         = timer_control[`CTL_TIMER_ON];
    assign prescale_select  = timer_control[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
    assign postscale_select = timer_control[`CTL_POSTSCALE_HI:`CTL_POSTSCALE_LO];

    // Instruction clock enable
    wire instr_tick;

    cycle_divider #(
        .RATIO (`INSTR_CLOCK_DIV)
    ) u_instr_div (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .tick_o (instr_tick)
    );

    // Prescaler terminal count
    reg [3:0] prescale_limit;

    always @* begin
        case (prescale_select)
            `PRESCALE_SEL_DIV1: prescale_limit = `PRESCALE_LIMIT_DIV1;
            `PRESCALE_SEL_DIV4: prescale_limit = `PRESCALE_LIMIT_DIV4;
            default:            prescale_limit = `PRESCALE_LIMIT_DIV16;
        endcase
    end

    // Scaler clear on counter or control write
    wire scaler_clear;
    wire pre_in;
    wire inc_tick;

    assign scaler_clear = count_write || control_write;
    assign pre_in       = instr_tick && timer_on;

    scale_counter #(
        .WIDTH (4)
    ) u_prescale (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .clear_i (scaler_clear),
        .pulse_i (pre_in),
        .limit_i (prescale_limit),
        .pulse_o (inc_tick)
    );

    // Counter and period match
    wire match_now;
    wire post_out;

    assign match_now = inc_tick && (timer_count == timer_period) && !count_write;

    reg [7:0] next_count;

    always @* begin
        next_count = timer_count;
        if (count_write) begin
            next_count = pwdata_i[7:0];
        end else if (inc_tick) begin
            if (timer_count == timer_period) begin
                next_count = 8'h00;
            end else begin
                next_count = timer_count + 8'h01;
            end
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_count <= `RST_TIMER_COUNT;
        end else begin
            timer_count <= next_count;
        end
    end

    scale_counter #(
        .WIDTH (4)
    ) u_postscale (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .clear_i (scaler_clear),
        .pulse_i (match_now),
        .limit_i (postscale_select),
        .pulse_o (post_out)
    );

    // Control register
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_control <= `RST_TIMER_CONTROL;
        end else if (control_write) begin
            timer_control <= pwdata_i[6:0];
        end
    end

    // Period register
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_period <= `RST_TIMER_PERIOD;
        end else if (period_write) begin
            timer_period <= pwdata_i[7:0];
        end
    end

    // Interrupt enables
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            peripheral_irq_enables <= `RST_PERIPHERAL_IRQ_ENABLES;
        end else if (enables_write) begin
            peripheral_irq_enables <= pwdata_i[7:0];
        end
    end

    // Interrupt control storage
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            interrupt_control <= `RST_INTERRUPT_CONTROL;
        end else if (interrupt_control_write) begin
            interrupt_control <= pwdata_i[7:0];
        end
    end

    // Sticky match flag; a set in the clearing cycle wins
    wire flag_read;
    wire flag_write;

    assign flag_read  = rd_done && hit_flags;
    assign flag_write = wr_done && hit_flags && lane0;

    reg next_flag;

    always @* begin
        next_flag = timer_match_flag;
        if (post_out) begin
            next_flag = 1'b1;
        end else if (flag_read) begin
            next_flag = 1'b0;
        end else if (flag_write) begin
            next_flag = pwdata_i[`BIT_TIMER_MATCH];
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_match_flag <= 1'b0;
        end else begin
            timer_match_flag <= next_flag;
        end
    end

    // Flag register view
    wire [7:0] flags_view;

    assign flags_view = {6'h00, timer_match_flag, 1'b0};

    // Read data mux
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        case (1'b1)
            hit_interrupt_control:  next_rdata = interrupt_control;
            hit_flags:   next_rdata = flags_view;
            hit_count:   next_rdata = timer_count;
            hit_control: next_rdata = {1'b0, timer_control};
            hit_enables: next_rdata = peripheral_irq_enables;
            hit_period:  next_rdata = timer_period;
            default:     next_rdata = 8'h00;
        endcase
    end

    // APB answer: ready in the first access cycle
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup_phase;
        end
    end

    // Error for an unmapped index
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup_phase && !hit_any;
        end
    end

    // Read data stands only with ready
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h00000000;
        end else if (setup_phase && !pwrite_i) begin
            prdata_o <= {24'h000000, next_rdata};
        end else begin
            prdata_o <= 32'h00000000;
        end
    end

    // Registered outputs to neighbours and interrupt line
    wire [7:0] next_pending;

    assign next_pending = flags_view & peripheral_irq_enables;

    // Interrupt line
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |next_pending;
        end
    end

    // Match to the serial port
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ssp_match_o <= 1'b0;
        end else begin
            ssp_match_o <= match_now;
        end
    end

    // Match to the PWM time base
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_match_o <= 1'b0;
        end else begin
            pwm_match_o <= match_now;
        end
    end

    // Counter copy for the PWM time base
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_count_o <= `RST_TIMER_COUNT;
        end else begin
            pwm_count_o <= timer_count;
        end
    end

    // Period copy for the PWM time base
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_period_o <= `RST_TIMER_PERIOD;
        end else begin
            pwm_period_o <= timer_period;
        end
    end
endmodule // period_match_timer_8bit

/* hw/scale_counter.v */
/*
 * Programmable scaler: passes one of every limit+1 input pulses.
 * Assumes pulses and clear are synchronous; clear wins over counting.
 */
`timescale 1ns/1ps
module scale_counter #(
    parameter WIDTH = 4
) (
    input  wire             clk_i,
    input  wire             nrst_i,
    input  wire             clear_i,
    input  wire             pulse_i,
    input  wire [WIDTH-1:0] limit_i,
    output wire             pulse_o
);
    reg [WIDTH-1:0] cnt;

    assign pulse_o = pulse_i && !clear_i && (cnt == limit_i);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= {WIDTH{1'b0}};
        end else if (clear_i) begin
            cnt <= {WIDTH{1'b0}};
        end else if (pulse_i) begin
            if (cnt >= limit_i) begin
                cnt <= {WIDTH{1'b0}};
            end else begin
                cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // scale_counter

/* verif/period_match_timer_8bit_checker.sv */
/* Port assertions of the period match timer.
   Assumes one clock and a bind from the bench top. */
`timescale 1ns/1ps
module period_match_timer_8bit_checker (
    input wire        clk_i,
    input wire        nrst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        irq_o,
    input wire        ssp_match_o,
    input wire        pwm_match_o,
    input wire [7:0]  pwm_count_o,
    input wire [7:0]  pwm_period_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_ready_after_setup: assert property ((psel_i && !penable_i) |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_match_spacing: assert property (ssp_match_o |=> !ssp_match_o [*3])
        else $error("matches too close");
    a_pwm_export: assert property (pwm_match_o == ssp_match_o)
        else $error("match exports differ");
    a_match_wraps: assert property (ssp_match_o |=> pwm_count_o == 8'h00)
        else $error("match without reload");
    a_match_at_period: assert property (ssp_match_o |-> pwm_count_o == pwm_period_o)
        else $error("match away from period");
    a_irq_sticky: assert property (irq_o && !psel_i && !$past(psel_i) |=> irq_o)
        else $error("interrupt dropped");
    c_match: cover property (ssp_match_o);
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (pslverr_o);
endmodule // period_match_timer_8bit_checker

/* verif/period_match_timer_8bit_tb.sv */
/* Self-checking bench of the period match timer over APB.
   Assumes a zero wait state slave and a 50 MHz clock. */
`timescale 1ns/1ps
module period_match_timer_8bit_tb;
    logic        clk_i;
    logic        nrst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        irq_o;
    logic        ssp_match_o;
    logic        pwm_match_o;
    logic [7:0]  pwm_count_o;
    logic [7:0]  pwm_period_o;
    logic [31:0] rd;
    logic        err;
    integer      num_errors = 0;
    integer      comparisons = 0;
    integer      n;
    integer      k;
    int          ratio [4] = '{1, 4, 16, 16};
    int          ps [3] = '{0, 1, 15};
    logic [11:0] addr [6] = '{12'h02c, 12'h030, 12'h044, 12'h048, 12'h230, 12'h248};

    period_match_timer_8bit dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
        .ssp_match_o(ssp_match_o), .pwm_match_o(pwm_match_o),
        .pwm_count_o(pwm_count_o), .pwm_period_o(pwm_period_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    // Cycles up to the next match pulse
    task automatic nextm();
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (ssp_match_o !== 1'b1 && k < 5000);
    endtask

    // Matches up to the one that raises the interrupt
    task automatic cntirq();
        n = 0;
        k = 0;
        while (irq_o !== 1'b1 && k < 5000) begin
            @(negedge clk_i);
            k++;
            if (ssp_match_o === 1'b1) n++;
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        complete_run();
    end

    initial begin
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        chk(pwm_period_o, 32'hff);
        for (int i = 0; i < 6; i++) rdchk(addr[i], i == 5 ? 32'hff : 32'h0);
        apb(1'b1, 12'h248, 8'h5a);
        rdchk(12'h248, 32'h5a);
        chk(pwm_period_o, 32'h5a);
        apb(1'b1, 12'h044, 8'h33);
        apb(1'b1, 12'h048, 8'hfb);
        rdchk(12'h048, 32'h7b);
        rdchk(12'h044, 32'h33);
        repeat (100) @(negedge clk_i);
        chk(pwm_count_o, 32'h33);
        rdchk(12'h3fc, 32'h0);
        chk(err, 1'b1);
        // Match spacing for periods 0 and 2 and each prescale
        for (int per = 0; per < 3; per += 2) begin
            apb(1'b1, 12'h248, per[7:0]);
            for (int p = 0; p < 4; p++) begin
                apb(1'b1, 12'h044, 8'h00);
                apb(1'b1, 12'h048, 8'h04 | p[7:0]);
                nextm();
                nextm();
                chk(k, (per + 1) * 4 * ratio[p]);
            end
        end
        // Postscaler, flag and interrupt
        apb(1'b1, 12'h248, 8'h00);
        apb(1'b1, 12'h230, 8'h02);
        for (int j = 0; j < 3; j++) begin
            apb(1'b1, 12'h048, {1'b0, ps[j][3:0], 3'h6});
            apb(1'b1, 12'h030, 8'h00);
            repeat (2) @(negedge clk_i);
            cntirq();
            chk(n, ps[j] + 1);
            rdchk(12'h030, 32'h02);
            repeat (2) @(negedge clk_i);
            chk(irq_o, 1'b0);
        end
        apb(1'b1, 12'h230, 8'h00);
        repeat (1100) @(negedge clk_i);
        chk(irq_o, 1'b0);
        rdchk(12'h030, 32'h02);
        // Scaler clear by control and count writes
        repeat (3) nextm();
        apb(1'b1, 12'h048, 8'h7e);
        apb(1'b1, 12'h230, 8'h02);
        cntirq();
        chk(n, 16);
        repeat (30) @(negedge clk_i);
        apb(1'b1, 12'h044, 8'h00);
        nextm();
        chk(k >= 62 && k <= 65, 1'b1);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdchk(12'h044, 32'h0);
        rdchk(12'h048, 32'h0);
        complete_run();
    end
endmodule // period_match_timer_8bit_tb

bind period_match_timer_8bit period_match_timer_8bit_checker chk_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .ssp_match_o(ssp_match_o), .pwm_match_o(pwm_match_o), .pwm_count_o(pwm_count_o),
    .pwm_period_o(pwm_period_o));
